// file: addr_map_pkg.sv
package addr_map_pkg;
  localparam int ADDR_W = 24;
  localparam int SEG_W = 8;
  localparam int OFS_W = 16;
  localparam int PAGE_W = 2;
  localparam int DATA_W = 16;
  localparam int BIT_W = 4;
  localparam logic [SEG_W-1:0] SEG_SYSTEM = 8'h00;
  localparam logic [SEG_W-1:0] SEG_ALT_ROM = 8'h01;
  localparam logic [OFS_W-1:0] ROM_AREA_END = 16'h7FFF;
  localparam logic [OFS_W-1:0] IRAM_BASE = 16'hF200;
  localparam logic [OFS_W-1:0] IRAM_END = 16'hFDFF;
  localparam logic [OFS_W-1:0] IRAM_BIT_BASE = 16'hFD00;
  localparam logic [OFS_W-1:0] EXT_REG_BASE = 16'hF000;
  localparam logic [OFS_W-1:0] EXT_REG_END = 16'hF1FF;
  localparam logic [OFS_W-1:0] EXT_REG_BIT_BASE = 16'hF100;
  localparam logic [OFS_W-1:0] SPEC_REG_BASE = 16'hFE00;
  localparam logic [OFS_W-1:0] SPEC_REG_BIT_BASE = 16'hFF00;
  localparam logic [OFS_W-1:0] TOP_AREA_BASE = 16'hF000;
  localparam logic [OFS_W-1:0] PERIPH_BASE = 16'hE000;
  localparam logic [OFS_W-1:0] PERIPH_END = 16'hE7FF;
  typedef enum logic [2:0] {
    TGT_EXTERNAL, TGT_PROGRAM, TGT_IRAM, TGT_SPEC_REG, TGT_EXT_REG, TGT_PERIPH, TGT_RESERVED
  } target_t;
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_DWORD, SIZE_BIT} size_t;
endpackage : addr_map_pkg

// file: decode_if.sv
`timescale 1ns/1ps
interface decode_if;
  import addr_map_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic fetch;
  logic rom_enable;
  logic rom_seg1;
  target_t target;
  logic bit_ok;
  logic fetch_bad;
  modport requester (output addr, fetch, rom_enable, rom_seg1, input target, bit_ok, fetch_bad);
  modport decoder (input addr, fetch, rom_enable, rom_seg1, output target, bit_ok, fetch_bad);
endinterface : decode_if

// file: area_decoder.sv
`timescale 1ns/1ps
module area_decoder
  import addr_map_pkg::*;
(
  decode_if.decoder dec
);
  logic [SEG_W-1:0] seg;
  logic [OFS_W-1:0] ofs;
  logic rom_seg_hit;
  always_comb begin
    seg = dec.addr[ADDR_W-1 -: SEG_W];
    ofs = dec.addr[OFS_W-1:0];
    rom_seg_hit = dec.rom_seg1 ? (seg == SEG_ALT_ROM) : (seg == SEG_SYSTEM);
    dec.target = TGT_EXTERNAL;
    dec.bit_ok = 1'b0;
    if (dec.rom_enable && rom_seg_hit && ofs <= ROM_AREA_END) begin
      dec.target = TGT_PROGRAM;
    end else if (seg == SEG_SYSTEM && ofs >= TOP_AREA_BASE) begin
      // top 4k of segment zero never leaves the chip
      if (ofs <= EXT_REG_END) begin
        dec.target = TGT_EXT_REG;
        dec.bit_ok = ofs >= EXT_REG_BIT_BASE;
      end else if (ofs < IRAM_BASE) begin
        dec.target = TGT_RESERVED;
      end else if (ofs <= IRAM_END) begin
        dec.target = TGT_IRAM;
        dec.bit_ok = ofs >= IRAM_BIT_BASE;
      end else begin
        dec.target = TGT_SPEC_REG;
        dec.bit_ok = ofs >= SPEC_REG_BIT_BASE;
      end
    end else if (seg == SEG_SYSTEM && ofs >= PERIPH_BASE && ofs <= PERIPH_END) begin
      dec.target = TGT_PERIPH;
    end
    dec.fetch_bad = dec.fetch && (dec.target == TGT_SPEC_REG || dec.target == TGT_EXT_REG
                    || dec.target == TGT_RESERVED);
  end
endmodule : area_decoder

// file: address_space_map.sv
`timescale 1ns/1ps
// Behaviour
// - Decode a 24-bit space of 256 segments of 64 kilobytes.
// - Each segment holds four 16-kilobyte data pages.
// - The top 4 kilobytes of segment zero go to internal RAM and register areas.
// - The bottom 32 kilobytes of segment zero may be the internal program area.
// - The program area may move to segment one or be switched off.
// - Register areas take data only; all other internal areas take code and data.
// - Words are little-endian, low byte at the even address; bytes use any address.
// - Double words are code only, two words at ascending addresses.
// - Bit 0 is the even byte's LSB and bit 15 the odd byte's MSB.
// - Bit addressing exists only in parts of the register areas, RAM and register bank.
// - All memories and peripherals share one common address space.
// - A configuration enable bit, loaded from the access pin at the first enabled clock after reset release, gates the program area.
// - A configuration select bit places the program area in segment zero or one.
module address_space_map
  import addr_map_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic EXT_ACCESS_N_IN,
  input wire logic CFG_WRITE_IN,
  input wire logic CFG_ROM_ENABLE_IN,
  input wire logic CFG_ROM_SEG1_IN,
  input wire logic REQ_VALID_IN,
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic REQ_FETCH_IN,
  input wire logic [1:0] REQ_SIZE_IN,
  input wire logic [BIT_W-1:0] REQ_BIT_IN,
  input wire logic [DATA_W-1:0] REQ_WDATA_IN,
  output logic ROM_ENABLE_OUT,
  output logic ROM_SEG1_OUT,
  output logic RSP_VALID_OUT,
  output logic [2:0] RSP_TARGET_OUT,
  output logic [SEG_W-1:0] RSP_SEG_OUT,
  output logic [PAGE_W-1:0] RSP_PAGE_OUT,
  output logic [ADDR_W-1:0] RSP_ADDR_OUT,
  output logic [1:0] RSP_BYTE_EN_OUT,
  output logic [DATA_W-1:0] RSP_WDATA_OUT,
  output logic RSP_EXTERNAL_OUT,
  output logic RSP_ERROR_OUT
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // configuration bits
  // ----------------------------------------
  logic rom_enable, next_rom_enable;
  logic rom_seg1, next_rom_seg1;
  logic strap_done, next_strap_done;
  always_comb begin
    next_rom_enable = rom_enable;
    next_rom_seg1 = rom_seg1;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      // pin level caught at first clock after release, not in the async branch
      next_rom_enable = !EXT_ACCESS_N_IN;
    end else if (CFG_WRITE_IN) begin
      next_rom_enable = CFG_ROM_ENABLE_IN;
      next_rom_seg1 = CFG_ROM_SEG1_IN;
    end
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rom_enable <= 1'b0;
      rom_seg1 <= 1'b0;
      strap_done <= 1'b0;
    end else if (CLK_EN_IN) begin
      rom_enable <= next_rom_enable;
      rom_seg1 <= next_rom_seg1;
      strap_done <= next_strap_done;
    end
  end
  assign ROM_ENABLE_OUT = rom_enable;
  assign ROM_SEG1_OUT = rom_seg1;

  // ----------------------------------------
  // area decode
  // ----------------------------------------
  decode_if dec ();
  assign dec.addr = REQ_ADDR_IN;
  assign dec.fetch = REQ_FETCH_IN;
  assign dec.rom_enable = rom_enable;
  assign dec.rom_seg1 = rom_seg1;
  area_decoder u_area_decoder (
    .dec(dec)
  );

  // ----------------------------------------
  // storage order and error checks
  // ----------------------------------------
  logic [1:0] byte_en;
  logic [DATA_W-1:0] lane_data;
  logic bad;
  always_comb begin
    byte_en = 2'h3;
    lane_data = REQ_WDATA_IN;
    bad = dec.fetch_bad;
    case (size_t'(REQ_SIZE_IN))
      SIZE_BYTE: begin
        // byte rides its own lane; either parity allowed
        byte_en = REQ_ADDR_IN[0] ? 2'h2 : 2'h1;
        lane_data = REQ_ADDR_IN[0] ? {REQ_WDATA_IN[7:0], 8'h00}
                                   : {8'h00, REQ_WDATA_IN[7:0]};
      end
      SIZE_WORD: begin
        bad = bad || REQ_ADDR_IN[0];
      end
      SIZE_DWORD: begin
        // master issues the two words at ascending addresses
        bad = bad || REQ_ADDR_IN[0] || !REQ_FETCH_IN;
      end
      SIZE_BIT: begin
        byte_en = REQ_BIT_IN[BIT_W-1] ? 2'h2 : 2'h1;
        lane_data = DATA_W'(1) << REQ_BIT_IN;
        bad = bad || !dec.bit_ok || REQ_ADDR_IN[0] || REQ_FETCH_IN;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // registered answer
  // ----------------------------------------
  logic rsp_valid, next_rsp_valid;
  logic [2:0] rsp_target, next_rsp_target;
  logic [ADDR_W-1:0] rsp_addr, next_rsp_addr;
  logic [1:0] rsp_be, next_rsp_be;
  logic [DATA_W-1:0] rsp_wdata, next_rsp_wdata;
  logic rsp_error, next_rsp_error;
  always_comb begin
    next_rsp_valid = REQ_VALID_IN;
    next_rsp_target = rsp_target;
    next_rsp_addr = rsp_addr;
    next_rsp_be = rsp_be;
    next_rsp_wdata = rsp_wdata;
    next_rsp_error = rsp_error;
    if (REQ_VALID_IN) begin
      next_rsp_target = 3'(dec.target);
      next_rsp_addr = REQ_ADDR_IN;
      next_rsp_be = bad ? 2'h0 : byte_en;
      next_rsp_wdata = lane_data;
      next_rsp_error = bad;
    end
  end
  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_target <= 3'h0;
      rsp_addr <= 24'h000000;
      rsp_be <= 2'h0;
      rsp_wdata <= 16'h0000;
      rsp_error <= 1'b0;
    end else if (CLK_EN_IN) begin
      rsp_valid <= next_rsp_valid;
      rsp_target <= next_rsp_target;
      rsp_addr <= next_rsp_addr;
      rsp_be <= next_rsp_be;
      rsp_wdata <= next_rsp_wdata;
      rsp_error <= next_rsp_error;
    end
  end
  assign RSP_VALID_OUT = rsp_valid;
  assign RSP_TARGET_OUT = rsp_target;
  assign RSP_ADDR_OUT = rsp_addr;
  assign RSP_SEG_OUT = rsp_addr[ADDR_W-1 -: SEG_W];
  assign RSP_PAGE_OUT = rsp_addr[OFS_W-1 -: PAGE_W];
  assign RSP_BYTE_EN_OUT = rsp_be;
  assign RSP_WDATA_OUT = rsp_wdata;
  assign RSP_ERROR_OUT = rsp_error;
  assign RSP_EXTERNAL_OUT = rsp_valid && !rsp_error
                            && rsp_target == 3'(TGT_EXTERNAL);
endmodule : address_space_map

// file: addr_map_checker_assertions.sv
`timescale 1ns/1ps
module addr_map_checker
  import addr_map_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic REQ_VALID_IN,
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic REQ_FETCH_IN,
  input wire logic [1:0] REQ_SIZE_IN,
  input wire logic ROM_ENABLE_OUT,
  input wire logic ROM_SEG1_OUT,
  input wire logic RSP_VALID_OUT,
  input wire logic [2:0] RSP_TARGET_OUT,
  input wire logic [SEG_W-1:0] RSP_SEG_OUT,
  input wire logic [PAGE_W-1:0] RSP_PAGE_OUT,
  input wire logic [ADDR_W-1:0] RSP_ADDR_OUT,
  input wire logic [1:0] RSP_BYTE_EN_OUT,
  input wire logic RSP_EXTERNAL_OUT,
  input wire logic RSP_ERROR_OUT
);
  wire req = CLK_EN_IN && REQ_VALID_IN;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_answer_next: assert property (req |=> RSP_VALID_OUT) else $error("no answer");
  a_no_extra: assert property (CLK_EN_IN && !REQ_VALID_IN |=> !RSP_VALID_OUT)
    else $error("spurious answer");
  a_ext_flag: assert property (RSP_EXTERNAL_OUT == (RSP_VALID_OUT && !RSP_ERROR_OUT
    && RSP_TARGET_OUT == 3'h0)) else $error("external flag");
  a_seg_page: assert property (RSP_VALID_OUT |-> {RSP_SEG_OUT, RSP_PAGE_OUT}
    == RSP_ADDR_OUT[23:14]) else $error("segment or page");
  a_odd_word: assert property (req && REQ_SIZE_IN == 2'h1 && REQ_ADDR_IN[0]
    |=> RSP_ERROR_OUT && RSP_BYTE_EN_OUT == 2'h0) else $error("odd word");
  a_reg_fetch: assert property (req && REQ_FETCH_IN && REQ_ADDR_IN[23:9] == 15'h007F
    |=> RSP_ERROR_OUT) else $error("register fetch");
  a_rom_claim: assert property (req && ROM_ENABLE_OUT
    && REQ_ADDR_IN[23:15] == {7'h00, ROM_SEG1_OUT, 1'b0}
    |=> RSP_TARGET_OUT == 3'h1) else $error("program area");
  a_dword_data: assert property (req && REQ_SIZE_IN == 2'h2 && !REQ_FETCH_IN
    |=> RSP_ERROR_OUT) else $error("data dword");
  cover property (req && REQ_SIZE_IN == 2'h3);
  cover property (RSP_VALID_OUT && RSP_TARGET_OUT == 3'h1 && ROM_SEG1_OUT);
  cover property (RSP_EXTERNAL_OUT);
endmodule : addr_map_checker
bind address_space_map addr_map_checker chk_u (.*);

// file: master_model.sv
`timescale 1ns/1ps
module master_model
  import addr_map_pkg::*;
(
  input wire logic clk_in,
  output logic vld_out,
  output logic [ADDR_W-1:0] adr_out,
  output logic fch_out,
  output logic [1:0] sz_out,
  output logic [BIT_W-1:0] bt_out,
  output logic [DATA_W-1:0] wd_out
);
  initial {vld_out, adr_out, fch_out, sz_out, bt_out, wd_out} = '0;
  // only parts with program memory are modelled, so its area is fair game
  task automatic go(input logic [46:0] r);
    @(posedge clk_in);
    #1;
    {adr_out, fch_out, sz_out, bt_out, wd_out} = r;
    vld_out = 1'b1;
  endtask : go
  task automatic idle();
    @(posedge clk_in);
    #1;
    vld_out = 1'b0;
    // released lines must not keep the stale address
    adr_out = ~adr_out;
    wd_out = ~wd_out;
  endtask : idle
endmodule : master_model

// file: address_space_map_bench.sv
`timescale 1ns/1ps
module address_space_map_bench
  import addr_map_pkg::*;
;
  typedef struct packed {logic e; logic [2:0] t; logic [1:0] b;
    logic [15:0] w; logic [23:0] a; logic [1:0] s;} note_t;
  logic SYS_CLK_IN = 1'b0;
  logic RESET_N_IN = 1'b0;
  logic CLK_EN_IN = 1'b1;
  logic EXT_ACCESS_N_IN = 1'b0;
  logic CFG_WRITE_IN = 1'b0;
  logic CFG_ROM_ENABLE_IN = 1'b1;
  logic CFG_ROM_SEG1_IN = 1'b0;
  logic REQ_VALID_IN, REQ_FETCH_IN, ROM_ENABLE_OUT, ROM_SEG1_OUT, RSP_VALID_OUT;
  logic RSP_EXTERNAL_OUT, RSP_ERROR_OUT;
  logic [ADDR_W-1:0] REQ_ADDR_IN, RSP_ADDR_OUT;
  logic [1:0] REQ_SIZE_IN, RSP_BYTE_EN_OUT;
  logic [BIT_W-1:0] REQ_BIT_IN;
  logic [DATA_W-1:0] REQ_WDATA_IN, RSP_WDATA_OUT;
  logic [2:0] RSP_TARGET_OUT;
  logic [SEG_W-1:0] RSP_SEG_OUT;
  logic [PAGE_W-1:0] RSP_PAGE_OUT;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  integer seed;
  note_t q[$];
  note_t n;
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  master_model m_u (.clk_in(SYS_CLK_IN), .vld_out(REQ_VALID_IN), .adr_out(REQ_ADDR_IN),
    .fch_out(REQ_FETCH_IN), .sz_out(REQ_SIZE_IN), .bt_out(REQ_BIT_IN), .wd_out(REQ_WDATA_IN));
  address_space_map dut_u (.*);
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [39:0] g, input logic [39:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  function automatic note_t ex(input logic [46:0] r);
    note_t n;
    logic [15:0] o;
    logic z;
    o = r[38:23];
    z = r[46:39] == 8'h00;
    {n.a, n.s, n.t} = {r[46:23], r[21:20], 3'h0};
    if (CFG_ROM_ENABLE_IN && !o[15] && r[46:39] == {7'h00, CFG_ROM_SEG1_IN}) n.t = 3'h1;
    else if (z && o >= 16'hE000) n.t = o >= 16'hFE00 ? 3'h3 : o >= 16'hF200 ? 3'h2
      : o >= 16'hF000 ? 3'h4 : o < 16'hE800 ? 3'h5 : 3'h0;
    n.e = r[22] && n.t inside {3'h3, 3'h4, 3'h6} || n.s != 2'h0 && r[23]
      || n.s == 2'h2 && !r[22]
      || n.s == 2'h3 && (r[22] || !(z && o[15:8] inside {8'hF1, 8'hFD, 8'hFF}));
    n.b = n.e ? 2'h0 : n.s == 2'h3 ? (r[19] ? 2'h2 : 2'h1)
      : n.s != 2'h0 ? 2'h3 : r[23] ? 2'h2 : 2'h1;
    n.w = n.s == 2'h3 ? 16'h1 << r[19:16] : n.s != 2'h0 ? r[15:0]
      : r[23] ? {r[7:0], 8'h00} : {8'h00, r[7:0]};
    return n;
  endfunction : ex
  task automatic acc(input logic [23:0] a, input logic f, input logic [1:0] s,
    input logic [3:0] b);
    logic [46:0] r;
    r = {a, f, s, b, 16'($random(seed))};
    q.push_back(ex(r));
    m_u.go(r);
  endtask : acc
  task automatic cfg(input logic e, input logic s1);
    @(posedge SYS_CLK_IN);
    #1;
    {CFG_WRITE_IN, CFG_ROM_ENABLE_IN, CFG_ROM_SEG1_IN} = {1'b1, e, s1};
    @(posedge SYS_CLK_IN);
    #1;
    CFG_WRITE_IN = 1'b0;
    chk(40'({ROM_ENABLE_OUT, ROM_SEG1_OUT}), 40'({e, s1}));
  endtask : cfg
  always @(posedge SYS_CLK_IN) begin
    if (RSP_VALID_OUT === 1'b1) begin
      n = q.pop_front();
      chk(40'({RSP_ERROR_OUT, RSP_TARGET_OUT, RSP_ADDR_OUT}), 40'({n.e, n.t, n.a}));
      chk(40'(RSP_BYTE_EN_OUT), 40'(n.b));
      if (!n.e) chk(40'(RSP_WDATA_OUT), 40'(n.w));
    end
  end
  always @(posedge SYS_CLK_IN) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    seed = 32'h0D7ADEA8;
    repeat (5) @(posedge SYS_CLK_IN);
    #1;
    RESET_N_IN = 1'b1;
    repeat (5) @(posedge SYS_CLK_IN);
    chk(40'({ROM_ENABLE_OUT, ROM_SEG1_OUT}), 40'h2);
    acc(24'h001234, 1'b0, 2'h0, 4'h0);
    acc(24'h00FE10, 1'b0, 2'h1, 4'h0);
    acc(24'h00F051, 1'b0, 2'h0, 4'h0);
    acc(24'h00F300, 1'b1, 2'h1, 4'h0);
    acc(24'h00FE02, 1'b1, 2'h1, 4'h0);
    acc(24'h00E100, 1'b0, 2'h1, 4'h0);
    acc(24'h008000, 1'b0, 2'h1, 4'h0);
    acc(24'h00F201, 1'b0, 2'h1, 4'h0);
    acc(24'h000100, 1'b1, 2'h2, 4'h0);
    acc(24'h000102, 1'b1, 2'h2, 4'h0);
    acc(24'h00F204, 1'b0, 2'h2, 4'h0);
    acc(24'h00FD00, 1'b0, 2'h3, 4'hF);
    acc(24'h00FF02, 1'b0, 2'h3, 4'h0);
    acc(24'h00F102, 1'b0, 2'h3, 4'h7);
    acc(24'h00F300, 1'b0, 2'h3, 4'h0);
    m_u.idle();
    for (int i = 0; i < 2; i++) begin
      cfg(i == 0, i == 0);
      acc(24'h010004, 1'b0, 2'h0, 4'h0);
      acc(24'h000004, 1'b0, 2'h1, 4'h0);
      m_u.idle();
    end
    // frozen clock enable must swallow a configuration write
    @(posedge SYS_CLK_IN);
    #1;
    CLK_EN_IN = 1'b0;
    {CFG_WRITE_IN, CFG_ROM_ENABLE_IN, CFG_ROM_SEG1_IN} = 3'h7;
    @(posedge SYS_CLK_IN);
    #1;
    chk(40'({ROM_ENABLE_OUT, ROM_SEG1_OUT}), 40'h0);
    {CFG_WRITE_IN, CFG_ROM_ENABLE_IN, CFG_ROM_SEG1_IN} = 3'h0;
    CLK_EN_IN = 1'b1;
    repeat (40) acc({1'b1, 23'($random(seed))}, 1'($random(seed)), 2'($random(seed)), 4'h5);
    m_u.idle();
    repeat (3) @(posedge SYS_CLK_IN);
    chk(40'(q.size()), 40'h0);
    stop_test();
  end
endmodule : address_space_map_bench
